// ---- hw/bdr_pkg.sv ----
package bdr_pkg;
   // register map, byte addresses on the APB side
   localparam logic [7:0]  OFS_DATA0     = 8'h00;
   localparam logic [7:0]  OFS_TRIM      = 8'h40;
   localparam logic [7:0]  OFS_STATUS    = 8'h44;
   localparam int          ADDR_W        = 8;

   // backup data words
   localparam int          NUM_WORDS     = 16;
   localparam int          WORD_W        = 16;
   localparam int          AIDX_W        = 4;
   localparam logic [15:0] DATA_RST      = 16'h0000;

   // trim and output control register fields
   localparam int          POS_PULSE_SEL = 9;
   localparam int          POS_PULSE_EN  = 8;
   localparam int          POS_CLK_OUT   = 7;
   localparam int          CAL_LSB       = 0;
   localparam int          CAL_W         = 7;
   localparam logic [6:0]  CAL_RST       = 7'h00;
   localparam logic        FLAG_RST      = 1'b0;

   // status register fields
   localparam int          POS_ST_UNLOCK = 0;
   localparam int          POS_ST_VDD    = 1;
   localparam int          POS_ST_PIN_OE = 2;
   localparam int          POS_ST_PIN    = 3;

   // pulse skipping window of 2^20 rtc pulses and divide-by-64 output
   localparam int          SKIP_W        = 20;
   localparam int          TRIM_DIV      = 64;
   localparam int          DIV_W         = 5;
   localparam logic [4:0]  DIV_LAST      = 5'(TRIM_DIV / 2 - 1);

   localparam logic [31:0] ZERO32        = 32'h0000_0000;

   typedef enum logic [0:0] {
      BDR_IDLE = 1'b0,
      BDR_ACK  = 1'b1
   } bdr_apb_e;
endpackage : bdr_pkg

// ---- hw/bdr_mem_if.sv ----
`timescale 1ns/1ps
interface bdr_mem_if;
   logic                          ce;
   logic                          clr;
   logic                          we;
   logic [bdr_pkg::AIDX_W-1:0]    waddr;
   logic [bdr_pkg::WORD_W-1:0]    wdata;
   logic [bdr_pkg::AIDX_W-1:0]    raddr;
   logic [bdr_pkg::WORD_W-1:0]    rdata;

   modport ctrl (output ce, output clr, output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input ce, input clr, input we, input waddr, input wdata, input raddr, output rdata);
endinterface : bdr_mem_if

// ---- hw/bdr_mem.sv ----
`timescale 1ns/1ps
module bdr_mem (
   input wire logic clk,
   bdr_mem_if.mem   bus
);
   import bdr_pkg::*;

   typedef struct packed {
      logic [NUM_WORDS-1:0][WORD_W-1:0] word;
      logic [WORD_W-1:0]                rdata;
   } bdr_mem_s;

   bdr_mem_s q;
   bdr_mem_s next_q;

   always_comb begin
      next_q = q;
      if (bus.ce) begin
         if (bus.we) begin
            next_q.word[bus.waddr] = bus.wdata;
         end
         next_q.rdata = q.word[bus.raddr];
      end
      // only the backup-domain reset clears the words
      if (bus.clr) begin
         next_q.word  = {NUM_WORDS{DATA_RST}};
         next_q.rdata = DATA_RST;
      end
   end

   always_ff @(posedge clk) begin
      q <= next_q;
   end

   assign bus.rdata = q.rdata;
endmodule : bdr_mem

// ---- hw/bdr_top.sv ----
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
// How it works
// - sixteen 16-bit backup data words hold 32 bytes of user data.
// - the data words survive system reset, power reset and standby wake and clear only on backup-domain reset.
// - after reset backup access is blocked until the write-unlock level is raised.
// - the pulse-select bit chooses the alarm pulse (0) or the second pulse (1) for the rtc pin.
// - with pulse-output-enable set and trim-clock-output clear the selected pulse, one rtc period long, drives the rtc pin.
// - pulse-select and pulse-output-enable clear only on backup-domain reset.
// - with trim-clock-output set the calibrated rtc clock divided by 64 drives the rtc pin.
// - trim-clock-output clears when the main supply goes off while CE is high and system reset is released.
// - the 7-bit skip field drops that many rtc pulses out of every 2^20.
// - each skip step slows the clock by 1000000/2^20 ppm, up to 121 ppm.
module bdr_top (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        BDRSTN,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        BACKUP_WRITE_UNLOCK,
   input  wire logic        VDD_GOOD,
   input  wire logic        RTC_CLK_IN,
   input  wire logic        RTC_ALARM_PULSE,
   input  wire logic        RTC_SECOND_PULSE,
   output logic             RTC_TICK,
   output logic             RTC_PIN_OUT,
   output logic             RTC_PIN_OE
);
   import bdr_pkg::*;

   typedef struct packed {
      bdr_apb_e          apb_st;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      logic              rtc_s1;
      logic              rtc_s2;
      logic              rtc_prev;
      logic              alm_s1;
      logic              alm_s2;
      logic              sec_s1;
      logic              sec_s2;
      logic              vdd_s1;
      logic              vdd_s2;
      logic              pulse_sel;
      logic              pulse_output_enable;
      logic              trim_clock_output;
      logic [CAL_W-1:0]  cal;
      logic [SKIP_W-1:0] skip_cnt;
      logic [DIV_W-1:0]  div_cnt;
      logic              div_clk;
      logic              rtc_tick;
      logic              pin_out;
      logic              pin_oe;
   } bdr_top_s;

   bdr_top_s  q;
   bdr_top_s  next_q;

   bdr_mem_if mbus ();

   logic              access;
   logic              aligned;
   logic              hit_data;
   logic              hit_trim;
   logic              hit_status;
   logic              mapped;
   logic              complete;
   logic              wr_ok;
   logic              rtc_edge;
   logic              keep_pulse;
   logic [15:0]       trim_word;
   logic [15:0]       status_word;

   bdr_mem u_mem (
      .clk (CLK),
      .bus (mbus)
   );

   // address decode; only whole aligned words are mapped
   always_comb begin
      access     = PSEL && PENABLE;
      aligned    = (PADDR[1:0] == 2'b00);
      hit_data   = aligned && (PADDR < OFS_TRIM);
      hit_trim   = aligned && (PADDR == OFS_TRIM);
      hit_status = aligned && (PADDR == OFS_STATUS);
      mapped     = hit_data || hit_trim || hit_status;
      // the request completes on the edge that samples pready high
      complete   = access && (q.apb_st == BDR_ACK);
      // locked backup domain drops writes silently
      wr_ok      = complete && PWRITE && BACKUP_WRITE_UNLOCK;
   end

   // the memory reads the addressed word during setup so it is ready in the access phase
   assign mbus.ce    = CE;
   assign mbus.clr   = !BDRSTN;
   assign mbus.we    = wr_ok && hit_data;
   assign mbus.waddr = PADDR[AIDX_W+1:2];
   assign mbus.wdata = PWDATA[WORD_W-1:0];
   assign mbus.raddr = PADDR[AIDX_W+1:2];

   always_comb begin
      trim_word                    = 16'h0000;
      trim_word[POS_PULSE_SEL]     = q.pulse_sel;
      trim_word[POS_PULSE_EN]      = q.pulse_output_enable;
      trim_word[POS_CLK_OUT]       = q.trim_clock_output;
      trim_word[CAL_LSB+:CAL_W]    = q.cal;
      status_word                  = 16'h0000;
      status_word[POS_ST_UNLOCK]   = BACKUP_WRITE_UNLOCK;
      status_word[POS_ST_VDD]      = q.vdd_s2;
      status_word[POS_ST_PIN_OE]   = q.pin_oe;
      status_word[POS_ST_PIN]      = q.pin_out;
   end

   // rising edge of the rtc clock as seen after the synchroniser
   assign rtc_edge   = q.rtc_s2 && !q.rtc_prev;
   // the first cal pulses of each 2^20 window are swallowed
   assign keep_pulse = (q.skip_cnt >= {{(SKIP_W-CAL_W){1'b0}}, q.cal});

   always_comb begin
      next_q = q;
      if (CE) begin
         // two-stage synchronisers for everything from other clocks or pins
         next_q.rtc_s1   = RTC_CLK_IN;
         next_q.rtc_s2   = q.rtc_s1;
         next_q.rtc_prev = q.rtc_s2;
         next_q.alm_s1   = RTC_ALARM_PULSE;
         next_q.alm_s2   = q.alm_s1;
         next_q.sec_s1   = RTC_SECOND_PULSE;
         next_q.sec_s2   = q.sec_s1;
         next_q.vdd_s1   = VDD_GOOD;
         next_q.vdd_s2   = q.vdd_s1;

         // apb slave: one wait state, then pready for a single cycle
         case (q.apb_st)
            BDR_IDLE: begin
               next_q.pready  = 1'b0;
               next_q.pslverr = 1'b0;
               if (access) begin
                  next_q.apb_st  = BDR_ACK;
                  next_q.pready  = 1'b1;
                  next_q.pslverr = !mapped;
                  next_q.prdata  = ZERO32;
                  if (!PWRITE) begin
                     if (hit_status) begin
                        next_q.prdata = {16'h0000, status_word};
                     end else if (BACKUP_WRITE_UNLOCK && hit_data) begin
                        next_q.prdata = {16'h0000, mbus.rdata};
                     end else if (BACKUP_WRITE_UNLOCK && hit_trim) begin
                        next_q.prdata = {16'h0000, trim_word};
                     end
                  end
               end
            end
            BDR_ACK: begin
               next_q.apb_st  = BDR_IDLE;
               next_q.pready  = 1'b0;
               next_q.pslverr = 1'b0;
               next_q.prdata  = ZERO32;
            end
            default: begin
               next_q.apb_st  = BDR_IDLE;
               next_q.pready  = 1'b0;
               next_q.pslverr = 1'b0;
            end
         endcase

         // trim register write, only while unlocked
         if (wr_ok && hit_trim) begin
            next_q.pulse_sel           = PWDATA[POS_PULSE_SEL];
            next_q.pulse_output_enable = PWDATA[POS_PULSE_EN];
            next_q.trim_clock_output   = PWDATA[POS_CLK_OUT];
            next_q.cal                 = PWDATA[CAL_LSB+:CAL_W];
         end

         // calibration: count every rtc pulse, pass only the kept ones
         next_q.rtc_tick = 1'b0;
         if (rtc_edge) begin
            next_q.skip_cnt = q.skip_cnt + 1'b1;
            next_q.rtc_tick = keep_pulse;
         end

         // divide the calibrated clock by 64: toggle every 32 kept pulses
         if (q.rtc_tick) begin
            next_q.div_cnt = q.div_cnt + 1'b1;
            if (q.div_cnt == DIV_LAST) begin
               next_q.div_clk = !q.div_clk;
            end
         end

         // pin mux; the divided clock wins if both outputs are requested
         if (q.trim_clock_output) begin
            next_q.pin_out = q.div_clk;
            next_q.pin_oe  = 1'b1;
         end else if (q.pulse_output_enable) begin
            // the pulses already last one rtc period, so they are passed level for level
            next_q.pin_out = q.pulse_sel ? q.sec_s2 : q.alm_s2;
            next_q.pin_oe  = 1'b1;
         end else begin
            next_q.pin_out = 1'b0;
            next_q.pin_oe  = 1'b0;
         end
      end

      // a main supply loss sampled before CE drops keeps clearing the clock output while frozen
      if (!q.vdd_s2) begin
         next_q.trim_clock_output = FLAG_RST;
      end

      // system reset touches only the bus side, the samplers, the tick and the pin outputs
      if (!RSTN) begin
         next_q.apb_st   = BDR_IDLE;
         next_q.pready   = 1'b0;
         next_q.pslverr  = 1'b0;
         next_q.prdata   = ZERO32;
         next_q.rtc_s1   = 1'b0;
         next_q.rtc_s2   = 1'b0;
         next_q.rtc_prev = 1'b0;
         next_q.alm_s1   = 1'b0;
         next_q.alm_s2   = 1'b0;
         next_q.sec_s1   = 1'b0;
         next_q.sec_s2   = 1'b0;
         next_q.vdd_s1   = 1'b1;
         next_q.vdd_s2   = 1'b1;
         next_q.rtc_tick = 1'b0;
         next_q.pin_out  = 1'b0;
         next_q.pin_oe   = 1'b0;
      end

      // backup-domain reset is the only one that clears the stored settings
      if (!BDRSTN) begin
         next_q.pulse_sel           = FLAG_RST;
         next_q.pulse_output_enable = FLAG_RST;
         next_q.trim_clock_output   = FLAG_RST;
         next_q.cal                 = CAL_RST;
         next_q.skip_cnt            = '0;
         next_q.div_cnt             = '0;
         next_q.div_clk             = 1'b0;
         next_q.rtc_tick            = 1'b0;
         next_q.pin_out             = 1'b0;
         next_q.pin_oe              = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      q <= next_q;
   end

   assign PRDATA      = q.prdata;
   assign PREADY      = q.pready;
   assign PSLVERR     = q.pslverr;
   assign RTC_TICK    = q.rtc_tick;
   assign RTC_PIN_OUT = q.pin_out;
   assign RTC_PIN_OE  = q.pin_oe;
endmodule : bdr_top

// ---- tb/bdr_asserts.sv ----
`timescale 1ns/1ps
module bdr_asserts (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        BACKUP_WRITE_UNLOCK,
   input wire logic        RTC_CLK_IN,
   input wire logic        RTC_TICK
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_ready_after_access:
      assert property (PSEL && PENABLE && $past(PSEL && !PENABLE) |=> PREADY) else $error("ready late");
   a_ready_single:
      assert property (PREADY |=> !PREADY) else $error("ready held");
   a_ready_needs_access:
      assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("ready without access");
   a_idle_quiet:
      assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR) else $error("bus not quiet");
   a_upper_zero:
      assert property (PREADY |-> PRDATA[31:16] == 16'h0000) else $error("upper bits set");
   a_locked_read_zero:
      assert property (PREADY && $past(!PWRITE && !BACKUP_WRITE_UNLOCK && PADDR <= 8'h40) |-> PRDATA == 32'h0)
         else $error("locked read leaks");
   a_unaligned_err:
      assert property (PREADY && $past(PADDR[1:0] != 2'b00) |-> PSLVERR) else $error("no error");
   a_tick_single:
      assert property (RTC_TICK |=> !RTC_TICK) else $error("tick held");
   a_tick_after_edge:
      assert property (RTC_TICK |-> ($past(RTC_CLK_IN, 2) || $past(RTC_CLK_IN, 3)) && !$past(RTC_CLK_IN, 5))
         else $error("tick not after rise");
endmodule : bdr_asserts

bind bdr_top bdr_asserts u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .BACKUP_WRITE_UNLOCK(BACKUP_WRITE_UNLOCK), .RTC_CLK_IN(RTC_CLK_IN), .RTC_TICK(RTC_TICK));

// ---- tb/bdr_rtc_model.sv ----
`timescale 1ns/1ps
module bdr_rtc_model #(
   parameter real HALF_NS = 28.0
) (
   input  wire logic run,
   input  wire logic want_alarm,
   input  wire logic want_second,
   output logic      rtc_clk,
   output logic      alarm,
   output logic      second,
   output int        n_edge
);
   initial begin
      rtc_clk = 1'b0;
      alarm = 1'b0;
      second = 1'b0;
      n_edge = 0;
   end
   // stands low while stopped so the skip window can be lined up
   // starts 1 ns off the bus clock grid so no rtc edge races a CLK edge
   initial begin
      #1;
      forever begin
         #HALF_NS;
         rtc_clk = run ? ~rtc_clk : 1'b0;
      end
   end
   always @(posedge rtc_clk) begin
      n_edge <= n_edge + 1;
      alarm <= want_alarm & ~alarm;
      second <= want_second & ~second;
   end
endmodule : bdr_rtc_model

// ---- tb/bdr_tb_top.sv ----
`timescale 1ns/1ps
module bdr_tb_top;
   import bdr_pkg::*;
   logic        clk, rstn, bdrstn, psel, penable, pwrite, unlock, vdd, run, w_al, w_se;
   logic        pready, pslverr, rtc_clk, al, se, tick, pin, oe, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_fail, checks_done, n_tick, n_edge, len, t0;

   bdr_top uut (.CLK(clk), .RSTN(rstn), .BDRSTN(bdrstn), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BACKUP_WRITE_UNLOCK(unlock), .VDD_GOOD(vdd), .RTC_CLK_IN(rtc_clk), .RTC_ALARM_PULSE(al),
      .RTC_SECOND_PULSE(se), .RTC_TICK(tick), .RTC_PIN_OUT(pin), .RTC_PIN_OE(oe));
   bdr_rtc_model rtc (.run(run), .want_alarm(w_al), .want_second(w_se), .rtc_clk(rtc_clk), .alarm(al),
      .second(se), .n_edge(n_edge));

   always #4 clk = ~clk;
   always @(posedge clk) if (tick === 1'b1) n_tick <= n_tick + 1;

   task report_and_stop;
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one idle cycle before each setup, so psel never changes twice in a step
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // outputs are read right after the edge, before the design's flops move on
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task pulse(input logic sec, output int l);
      int n;
      @(posedge clk);
      if (sec) w_se <= 1'b1;
      else w_al <= 1'b1;
      for (n = 0; n < 20 && !(al || se); n++) @(negedge clk);
      @(posedge clk);
      w_al <= 1'b0;
      w_se <= 1'b0;
      l = 0;
      repeat (30) begin
         @(negedge clk);
         if (pin === 1'b1) l++;
      end
   endtask : pulse

   task pin_rise;
      int n;
      logic p;
      n = 0;
      p = 1'b1;
      while (!(p === 1'b0 && pin === 1'b1) && n < 3000) begin
         p = pin;
         @(negedge clk);
         n++;
      end
   endtask : pin_rise

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end

   initial begin
      {clk, rstn, bdrstn, psel, penable, pwrite, unlock, run, w_al, w_se} = '0;
      {paddr, pwdata, n_fail, checks_done} = '0;
      vdd = 1'b1;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      bdrstn <= 1'b1;
      apb(1'b1, OFS_DATA0, 32'h1234);
      apb(1'b0, OFS_DATA0, ZERO32); chk(rd, ZERO32);
      unlock <= 1'b1;
      apb(1'b0, OFS_DATA0, ZERO32); chk(rd, {16'h0, DATA_RST});
      // rtc held still so the skip window starts with the first edge
      apb(1'b1, OFS_TRIM, 32'h5);
      run <= 1'b1;
      repeat (200) @(posedge clk);
      run <= 1'b0;
      repeat (20) @(posedge clk);
      chk(32'(n_tick), 32'(n_edge - 5));
      for (int i = 0; i < NUM_WORDS; i++) apb(1'b1, 8'(4 * i), {16'hFFFF, 16'(i * 4369) ^ 16'h5A5A});
      for (int i = 0; i < NUM_WORDS; i++) begin
         apb(1'b0, 8'(4 * i), ZERO32); chk(rd, {16'h0, 16'(i * 4369) ^ 16'h5A5A});
      end
      unlock <= 1'b0;
      apb(1'b1, OFS_DATA0, 32'hBEEF);
      apb(1'b1, OFS_TRIM, 32'h3FF);
      unlock <= 1'b1;
      apb(1'b0, OFS_DATA0, ZERO32); chk(rd, 32'h5A5A);
      apb(1'b0, OFS_TRIM, ZERO32); chk(rd, 32'h5);
      apb(1'b1, OFS_TRIM, 32'h37F);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, 8'h3C, ZERO32); chk(rd, {16'h0, 16'(15 * 4369) ^ 16'h5A5A});
      apb(1'b0, OFS_TRIM, ZERO32); chk(rd, 32'h37F);
      run <= 1'b1;
      apb(1'b1, OFS_TRIM, 32'h100);
      pulse(1'b1, len); chk(32'(len), 0);
      pulse(1'b0, len); chk(32'(len >= 6 && len <= 8), 1);
      apb(1'b1, OFS_TRIM, 32'h300);
      pulse(1'b1, len); chk(32'(len >= 6 && len <= 8), 1);
      apb(1'b1, OFS_TRIM, 32'h080);
      // the first rise may only be the mux switching over, so line up on a real one
      pin_rise();
      pin_rise();
      t0 = n_tick;
      pin_rise(); chk(32'(n_tick - t0), TRIM_DIV);
      chk(oe, 1'b1);
      apb(1'b1, OFS_TRIM, 32'h380);
      vdd <= 1'b0;
      repeat (8) @(posedge clk);
      vdd <= 1'b1;
      apb(1'b0, OFS_TRIM, ZERO32); chk(rd, 32'h300);
      apb(1'b0, 8'h48, ZERO32); chk(er, 1'b1);
      apb(1'b0, 8'h02, ZERO32); chk(er, 1'b1);
      bdrstn <= 1'b0;
      @(posedge clk);
      bdrstn <= 1'b1;
      apb(1'b0, 8'h3C, ZERO32); chk(rd, ZERO32);
      apb(1'b0, OFS_TRIM, ZERO32); chk(rd, ZERO32);
      apb(1'b0, OFS_STATUS, ZERO32); chk(rd, 32'h3);
      report_and_stop();
   end
endmodule : bdr_tb_top
